// File: dv/pcx_cfg_chk_asserts.sv
`timescale 1ns/1ns
module pcx_cfg_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // config and i/o bus
  input wire logic cfgReq,
  input wire logic cfgWe,
  input wire logic [7:0] cfgAddr,
  input wire logic cfgAck,
  input wire logic [31:0] cfgRdata,
  input wire logic ioReq,
  input wire logic ioAck
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // taken reads per header dword
  wire rd = cfgReq && clkEn && !cfgWe;
  wire rH = rd && cfgAddr[7:2] == 6'h03;
  wire rB = rd && cfgAddr[7:2] == 6'h04;
  wire rI = rd && cfgAddr[7:2] == 6'h0f;
  //////////////////////////////////////////////
  AST_SELF: assert property (rH |=> cfgRdata[31:24] == 8'h00)
    else $error("self-test byte set");
  AST_HDR: assert property (rH |=> cfgRdata[23:16] == 8'h00)
    else $error("header type set");
  AST_LAT: assert property (rH |=> cfgRdata[15:8] == 8'h00)
    else $error("latency timer set");
  AST_CACHE: assert property (rH |=> cfgRdata[7:0] == 8'h00)
    else $error("cache line set");
  AST_BARLO: assert property (rB |=> cfgRdata[1:0] == 2'h1)
    else $error("bar low bits wrong");
  AST_PIN: assert property (rI |=> cfgRdata[15:8] == 8'h01)
    else $error("int pin wrong");
  AST_MAXL: assert property (rI |=> cfgRdata[31:24] == 8'h00)
    else $error("max latency set");
  AST_CACK: assert property (cfgReq && clkEn |=> cfgAck)
    else $error("config ack missing");
  AST_IACK: assert property (ioReq && clkEn |=> ##1 ioAck)
    else $error("i/o ack missing");
  // main scenarios reached
  cover property (rB);
  cover property (rI);
  cover property (ioAck);
endmodule
bind pcx_pci_config_port pcx_cfg_chk chk_u (
  .sys_clk, .nrst, .clkEn, .cfgReq, .cfgWe, .cfgAddr,
  .cfgAck, .cfgRdata, .ioReq, .ioAck
);

// File: dv/pcx_host_model.sv
`timescale 1ns/1ns
module pcx_host_model (
  // clock
  input wire logic sys_clk,
  // config cycles
  output logic cfgReq,
  output logic cfgWe,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgBe,
  output logic [31:0] cfgWdata,
  input wire logic cfgAck,
  input wire logic [31:0] cfgRdata,
  // i/o cycles
  output logic ioReq,
  output logic ioWe,
  output logic [31:0] ioAddr,
  output logic [3:0] ioBe,
  output logic [31:0] ioWdata,
  input wire logic ioAck,
  input wire logic ioHit,
  input wire logic [31:0] ioRdata
);
  // idle bus from time zero
  initial begin
    {cfgReq, cfgWe, cfgAddr, cfgBe, cfgWdata} = '0;
    {ioReq, ioWe, ioAddr, ioBe, ioWdata} = '0;
  end
  //////////////////////////////////////////////
  // one-cycle request, answer one edge later
  task automatic cfg(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(negedge sys_clk);
    {cfgReq, cfgWe, cfgAddr} = {2'b10 | w, a};
    {cfgBe, cfgWdata} = {4'hf, d};
    @(negedge sys_clk);
    cfgReq = 1'b0;
    cfgWdata = ~d; // released data must not linger
    r = cfgAck ? cfgRdata : 'x;
  endtask
  // i/o answer lands two edges after the request
  task automatic io(input logic w, input logic [31:0] a,
      input logic [3:0] b, input logic [31:0] d,
      output logic [31:0] r, output logic h);
    @(negedge sys_clk);
    {ioReq, ioWe, ioAddr, ioBe, ioWdata} = {2'b10 | w, a, b, d};
    @(negedge sys_clk);
    ioReq = 1'b0;
    ioWdata = ~d;
    @(negedge sys_clk);
    r = ioAck ? ioRdata : 'x;
    h = ioAck ? ioHit : 1'bx;
  endtask
endmodule

// File: dv/test_pci_config_and_index_port.sv
`timescale 1ns/1ns
module test_pci_config_and_index_port;
  import pcx_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst, clkEn, cfgReq, cfgWe, cfgAck, hit;
  logic ioReq, ioWe, ioAck, ioHit, sockReq, sockWe, sockSel;
  logic [7:0] cfgAddr, sockWdata, sockRdata;
  logic [3:0] cfgBe, ioBe;
  logic [5:0] sockReg;
  logic [31:0] cfgWdata, cfgRdata, ioAddr, ioWdata, ioRdata, rd;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  // socket registers answer with their own select
  assign sockRdata = {sockSel, sockWe, sockReg};
  // last socket request as the far side saw it
  logic [15:0] sockSeen = '0;
  always @(negedge sys_clk) begin
    if (sockReq) begin
      sockSeen <= {sockWe, sockSel, sockReg, sockWdata};
    end
  end
  pcx_pci_config_port dut_u (.sys_clk, .nrst, .clkEn, .cfgReq,
    .cfgWe, .cfgAddr, .cfgBe, .cfgWdata, .cfgAck, .cfgRdata,
    .ioReq, .ioWe, .ioAddr, .ioBe, .ioWdata, .ioAck, .ioHit,
    .ioRdata, .sockReq, .sockWe, .sockSel, .sockReg,
    .sockWdata, .sockRdata);
  pcx_host_model host_u (.sys_clk, .cfgReq, .cfgWe, .cfgAddr,
    .cfgBe, .cfgWdata, .cfgAck, .cfgRdata, .ioReq, .ioWe,
    .ioAddr, .ioBe, .ioWdata, .ioAck, .ioHit, .ioRdata);
  //////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // values straight out of reset
  task automatic t_reset();
    host_u.cfg(1'b0, CFG_OFS_HDR, '0, rd);
    chk("hdr", rd, 32'h0);
    host_u.cfg(1'b0, CFG_OFS_BAR, '0, rd);
    chk("bar", rd, 32'h1);
    host_u.cfg(1'b0, CFG_OFS_INT, '0, rd);
    chk("int", rd, 32'h100);
    host_u.io(1'b0, 32'h0, 4'h1, '0, rd, hit);
    chk("idx", rd, 32'h0);
    $display("reset test done");
  endtask
  // writes to fixed bytes leave them alone
  task automatic t_fixed();
    host_u.cfg(1'b1, CFG_OFS_HDR, '1, rd);
    host_u.cfg(1'b1, CFG_OFS_INT, '1, rd);
    host_u.cfg(1'b0, CFG_OFS_HDR, '0, rd);
    chk("hdr", rd, 32'h0);
    host_u.cfg(1'b0, CFG_OFS_INT, '0, rd);
    chk("int", rd, 32'h1ff);
    host_u.cfg(1'b1, CFG_OFS_BAR, '1, rd);
    host_u.cfg(1'b0, CFG_OFS_BAR, '0, rd);
    chk("bar", rd, 32'hffff_fffd);
    $display("fixed test done");
  endtask
  // clock enable low: a request is not taken
  task automatic t_freeze();
    clkEn = 1'b0;
    host_u.cfg(1'b1, CFG_OFS_INT, 32'h0, rd);
    clkEn = 1'b1;
    host_u.cfg(1'b0, CFG_OFS_INT, '0, rd);
    chk("frz", rd, 32'h1ff);
    $display("freeze test done");
  endtask
  // index then data at the new base, both sockets
  task automatic t_index();
    logic [7:0] iv [2] = '{8'hc5, 8'h3f};
    host_u.cfg(1'b1, CFG_OFS_BAR, 32'h1000, rd);
    foreach (iv[i]) begin
      host_u.io(1'b1, 32'h1000, 4'h1, {24'h0, iv[i]}, rd, hit);
      host_u.io(1'b0, 32'h1001, 4'h3, '0, rd, hit);
      chk("hit", {31'h0, hit}, 32'h1);
      chk("pair", rd, {16'h0, iv[i][6], 1'b0, iv[i][5:0],
        iv[i]});
    end
    host_u.io(1'b1, 32'h1001, 4'h2, 32'h0000_a500, rd, hit);
    chk("wrd", rd, 32'h0);
    chk("sockw", {16'h0, sockSeen}, {17'h1, iv[1][6:0], 8'ha5});
    host_u.io(1'b0, 32'h1004, 4'h3, '0, rd, hit);
    chk("miss", {31'h0, hit}, 32'h0);
    chk("missd", rd, 32'h0);
    $display("index test done");
  endtask
  // hang guard, run needs well under a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    t_fixed();
    t_freeze();
    t_index();
    finish_test();
  end
endmodule

// File: hdl/pcx_index_port.sv
`timescale 1ns/1ns
module pcx_index_port
  import pcx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // decoded access to the register pair
  input wire logic hitReq,
  input wire logic hitWe,
  input wire logic [1:0] hitBe,
  input wire logic [15:0] hitWdata,
  // index register value
  output logic [7:0] indexVal,
  // socket register access
  output logic sockReq,
  output logic sockWe,
  output logic sockSel,
  output logic [5:0] sockReg,
  output logic [7:0] sockWdata
);

  logic [7:0] index_q;
  logic sockReq_q;
  logic sockWe_q;
  logic sockSel_q;
  logic [5:0] sockReg_q;
  logic [7:0] sockWdata_q;

  //////////////////////////////////////////////////////////////////////////
  // index register, all eight bits stored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      index_q <= IDX_RESET;
    end else if (clkEn && hitReq && hitWe && hitBe[OPS_LANE_INDEX]) begin
      index_q <= hitWdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data lane access forwarded using the index held before this access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sockReq_q <= 1'b0;
      sockWe_q <= 1'b0;
      sockSel_q <= 1'b0;
      sockReg_q <= 6'h00;
      sockWdata_q <= 8'h00;
    end else if (clkEn) begin
      sockReq_q <= hitReq && hitBe[OPS_LANE_DATA];
      if (hitReq && hitBe[OPS_LANE_DATA]) begin
        sockWe_q <= hitWe;
        sockSel_q <= index_q[IDX_SOCK_BIT];
        sockReg_q <= index_q[IDX_REG_MSB:0];
        sockWdata_q <= hitWdata[15:8];
      end
    end
  end

  assign indexVal = index_q;
  assign sockReq = sockReq_q;
  assign sockWe = sockWe_q;
  assign sockSel = sockSel_q;
  assign sockReg = sockReg_q;
  assign sockWdata = sockWdata_q;

endmodule

// File: hdl/pcx_pci_config_port.sv
`timescale 1ns/1ns
module pcx_pci_config_port
  import pcx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // configuration cycles
  input wire logic cfgReq,
  input wire logic cfgWe,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgBe,
  input wire logic [31:0] cfgWdata,
  output logic cfgAck,
  output logic [31:0] cfgRdata,
  // i/o cycles
  input wire logic ioReq,
  input wire logic ioWe,
  input wire logic [31:0] ioAddr,
  input wire logic [3:0] ioBe,
  input wire logic [31:0] ioWdata,
  output logic ioAck,
  output logic ioHit,
  output logic [31:0] ioRdata,
  // socket register side
  output logic sockReq,
  output logic sockWe,
  output logic sockSel,
  output logic [5:0] sockReg,
  output logic [7:0] sockWdata,
  input wire logic [7:0] sockRdata
);

  //////////////////////////////////////////////////////////////////////////
  // timing at a glance
  // config request taken on an enabled edge, answered on the next
  // config read data holds until the next taken config request
  // config write answers carry zero data
  // i/o request taken on an enabled edge, answered two edges later
  // every i/o request is answered, a miss with no hit and zero data
  // socket request stands in the cycle between those two edges
  // socket read data is sampled at the end of that cycle
  // back to back requests are fine on both buses, nothing is refused
  // clkEn low freezes every register here, outputs included
  // reset clears base, interrupt line, index and every output
  // first request may come on the first edge after reset
  // pairing: a request touching both lanes uses the old index for data
  // and the index lane of that read returns the old index as well
  // index bit 7 has no meaning but is stored and reads back
  // the interrupt line value steers nothing in this block
  // trade-off: fixed latency keeps the host side simple, but the
  // socket side must answer combinationally within one cycle

  //////////////////////////////////////////////////////////////////////////
  // helpers
  // small pure functions, no state

  // merge written byte lanes into a stored word
  // shared by every writable slot so partial writes behave alike
  function automatic logic [31:0] beMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction

  // dword compare of a byte offset against a header slot
  // low two offset bits never take part in the decode
  function automatic logic cfgIs(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr[7:2] == ofs[7:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // configuration state
  // header slots decoded here, every other slot reads zero
  //   0x0c  self-test, header type, latency timer, cache line
  //   0x10  i/o base of the operation pair, type bits fixed
  //   0x3c  max latency, min grant, interrupt pin, interrupt line
  // only the base bits and the interrupt line hold any state
  // writes to fixed bytes are answered but change nothing
  // partial writes merge lane by lane

  // stored fields
  logic [31:2] barBase_q;
  logic [7:0] intLine_q;

  // answer registers
  logic cfgAck_q;
  logic [31:0] cfgRdata_q;

  // read views and merged write values
  logic [31:0] barWord;
  logic [31:0] barMerged;
  logic [31:0] hdrWord;
  logic [31:0] intWord;
  logic [31:0] intMerged;

  // assembled read views, fixed fields come from constants only
  // so no write path can ever reach them
  assign hdrWord = {
    SELFTEST_VAL,
    HDR_TYPE_VAL,
    LAT_TIMER_VAL,
    CACHE_LINE_VAL
  };
  assign barWord = {
    barBase_q,
    BAR_RSVD_VAL,
    BAR_IO_VAL
  };
  assign intWord = {
    MAX_LAT_VAL,
    MIN_GNT_VAL,
    INT_PIN_VAL,
    intLine_q
  };
  assign barMerged = beMerge(barWord, cfgWdata, cfgBe);
  assign intMerged = beMerge(intWord, cfgWdata, cfgBe);

  // base address: only bits above the type bits take writes
  // the low type bits are rebuilt from constants on every read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      barBase_q <= BAR_RESET;
    end else if (clkEn && cfgReq && cfgWe && cfgIs(cfgAddr, CFG_OFS_BAR)) begin
      barBase_q <= barMerged[31:BAR_BASE_LSB];
    end
  end

  // interrupt line is a scratch byte; routing lives behind the data port
  // kept only so configuration software reads back what it wrote
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      intLine_q <= INT_LINE_RESET;
    end else if (clkEn && cfgReq && cfgWe && cfgIs(cfgAddr, CFG_OFS_INT)) begin
      intLine_q <= intMerged[7:0];
    end
  end

  // config answer one edge after the request; unknown slots read zero
  // a write answer carries zero, so no stale read data leaks out
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfgAck_q <= 1'b0;
      cfgRdata_q <= 32'h0000_0000;
    end else if (clkEn) begin
      cfgAck_q <= cfgReq;
      if (cfgReq && !cfgWe) begin
        if (cfgIs(cfgAddr, CFG_OFS_HDR)) begin
          cfgRdata_q <= hdrWord;
        end else if (cfgIs(cfgAddr, CFG_OFS_BAR)) begin
          cfgRdata_q <= barWord;
        end else if (cfgIs(cfgAddr, CFG_OFS_INT)) begin
          cfgRdata_q <= intWord;
        end else begin
          cfgRdata_q <= 32'h0000_0000;
        end
      end else if (cfgReq) begin
        cfgRdata_q <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // i/o decode of the operation register pair
  // one dword at the programmed base
  //   lane 0  index register
  //   lane 1  data register, forwarded to the socket side
  //   lanes 2 and 3 claimed but ignored
  // limitation: no i/o enable gate here, the decode is always live,
  // so a zero base after reset claims addresses 0 to 3

  // decode results
  logic ioMatch;
  logic pairHit;
  logic [7:0] indexVal;

  // first stage, request remembered
  logic pend_q;
  logic pendHit_q;
  logic pendRd_q;
  logic [1:0] pendBe_q;
  logic [7:0] pendIndex_q;

  // second stage, answer registers
  logic ioAck_q;
  logic ioHit_q;
  logic [31:0] ioRdata_q;
  logic [31:0] pairRdata;

  // one dword claimed; lanes above the pair are ignored
  // a request with neither pair lane enabled does not reach the pair
  assign ioMatch = ioAddr[31:BAR_BASE_LSB] == barBase_q;
  assign pairHit = ioReq &&
                   ioMatch &&
                   (ioBe[1:0] != 2'b00);

  // index register and socket request live in their own module
  pcx_index_port u_index (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .hitReq(pairHit),
    .hitWe(ioWe),
    .hitBe(ioBe[1:0]),
    .hitWdata(ioWdata[15:0]),
    .indexVal(indexVal),
    .sockReq(sockReq),
    .sockWe(sockWe),
    .sockSel(sockSel),
    .sockReg(sockReg),
    .sockWdata(sockWdata)
  );

  // first stage: remember the access and the index it saw
  // the index is captured before this access can change it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      pendHit_q <= 1'b0;
      pendRd_q <= 1'b0;
      pendBe_q <= 2'b00;
      pendIndex_q <= IDX_RESET;
    end else if (clkEn) begin
      pend_q <= ioReq;
      if (ioReq) begin
        pendHit_q <= ioMatch;
        pendRd_q <= !ioWe;
        pendBe_q <= ioBe[1:0];
        pendIndex_q <= indexVal;
      end
    end
  end

  // read word of the pair; writes, misses and idle lanes give zero
  // kept apart from the flop so the lane rules sit in one place
  always_comb begin
    pairRdata = 32'h0000_0000;
    if (pendHit_q && pendRd_q) begin
      if (pendBe_q[OPS_LANE_INDEX]) begin
        pairRdata[7:0] = pendIndex_q;
      end
      if (pendBe_q[OPS_LANE_DATA]) begin
        pairRdata[15:8] = sockRdata;
      end
    end
  end

  // second stage: socket data is sampled while its request stands
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ioAck_q <= 1'b0;
      ioHit_q <= 1'b0;
      ioRdata_q <= 32'h0000_0000;
    end else if (clkEn) begin
      ioAck_q <= pend_q;
      if (pend_q) begin
        ioHit_q <= pendHit_q;
        ioRdata_q <= pairRdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  // every output below is a plain flop, no logic after it

  assign cfgAck = cfgAck_q;
  assign cfgRdata = cfgRdata_q;
  assign ioAck = ioAck_q;
  assign ioHit = ioHit_q;
  assign ioRdata = ioRdata_q;

endmodule

// File: hdl/pcx_pkg.sv
package pcx_pkg;

  // configuration header dword offsets (byte addresses)
  localparam logic [7:0] CFG_OFS_HDR = 8'h0c;
  localparam logic [7:0] CFG_OFS_BAR = 8'h10;
  localparam logic [7:0] CFG_OFS_INT = 8'h3c;

  // fixed header bytes
  localparam logic [7:0] SELFTEST_VAL = 8'h00;
  localparam logic [7:0] HDR_TYPE_VAL = 8'h00;
  localparam logic [7:0] LAT_TIMER_VAL = 8'h00;
  localparam logic [7:0] CACHE_LINE_VAL = 8'h00;

  // base address register layout
  localparam int BAR_IO_BIT = 0;
  localparam int BAR_RSVD_BIT = 1;
  localparam int BAR_BASE_LSB = 2;
  localparam logic BAR_IO_VAL = 1'b1;
  localparam logic BAR_RSVD_VAL = 1'b0;
  localparam logic [31:2] BAR_RESET = 30'h0000_0000;

  // interrupt and latency dword
  localparam logic [7:0] INT_LINE_RESET = 8'h00;
  localparam logic [7:0] INT_PIN_VAL = 8'h01;
  localparam logic [7:0] MIN_GNT_VAL = 8'h00;
  localparam logic [7:0] MAX_LAT_VAL = 8'h00;

  // max latency unit, and its length in bus clocks
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAX_LAT_UNIT_NS = 250;
  localparam int MAX_LAT_UNIT_CYC =
    (MAX_LAT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operation register pair, byte lanes within the decoded dword
  localparam int OPS_LANE_INDEX = 0;
  localparam int OPS_LANE_DATA = 1;

  // index register layout
  localparam int IDX_RSVD_BIT = 7;
  localparam int IDX_SOCK_BIT = 6;
  localparam int IDX_REG_MSB = 5;
  localparam logic [7:0] IDX_RESET = 8'h00;

endpackage
